// [cbc_cfg.svh]
// Offsets, field positions, reset values and masks of the core and bus clock unit.
// Assumes a 12-bit byte address from the register port and a 200 MHz clk_sys.
//
// What this block does
// - Core source select bits 26:24, codes 0-6 pick sources; core clock undivided.
// - Core AXI clock is core source divided by bits 1:0 plus one; reset 1.
// - Second core divider N is bits 9:8 plus one; resets to 3.
// - Core PLL divider P bits 17:16 divides by 1, 2, 4; below 288 MHz.
// - Core and bus selectors, AXI and bus dividers change glitch free while running; core P and N apply the cycle after the write.
// - Core gate bit 31 resets on; changes only when key 16'h16AA written.
// - System bus source bits 25:24; output divided by M then N of 1,2,4,8.
// - System bus divider M is bits 1:0 plus one.
// - Peripheral bus 0 source bits 25:24 incl. system bus; divided by M, N.
// - Peripheral bus 1 same sources and division as bus 0, own register.
// - Peripheral, display and deinterlacer M is 5-bit bits 4:0 plus one.
// - Memory bus register resets C000_0000, only bit 30 stored (reads 4000_0000); bit 30 low asserts reset.
// - Memory bus clock is DDR PLL divided by four.
// - Display clock: gate bit 31, source bits 26:24, divided by M.
// - Display bus register: reset release bit 16, bus gate bit 0, both zero.
// - Deinterlacer clock has the same gate, sources and M as display clock.
// - Core PLL bias: VCO reset-in bit 31 resets one; bias bits 20:16.
// - Each other PLL bias register: bits 20:16 read-write, reset 3.
// - Tuning: VCO range 30:28, gain 26:24 reset 4; counter 22:16 reset 40h.
// - Tuning: verify input 14:8 resets 40h; overrides bits 15 and 7 zero.
// - Tuning bits 6:0 read-only verify output, reset zero, writes ignored.
`ifndef CBC_CFG_SVH
`define CBC_CFG_SVH

`define CBC_OFF_CORE_PLL_BIAS 12'h300
`define CBC_OFF_DDR_PLL_BIAS 12'h310
`define CBC_OFF_PERI_PLL_BIAS 12'h320
`define CBC_OFF_VIDEO_A_BIAS 12'h340
`define CBC_OFF_VIDEO_B_BIAS 12'h348
`define CBC_OFF_VE_PLL_BIAS 12'h358
`define CBC_OFF_AUDIO_A_BIAS 12'h378
`define CBC_OFF_AUDIO_B_BIAS 12'h380
`define CBC_OFF_CORE_TUNING 12'h400
`define CBC_OFF_CORE_CONFIG 12'h500
`define CBC_OFF_CORE_GATE 12'h504
`define CBC_OFF_SYS_BUS 12'h510
`define CBC_OFF_PBUS0 12'h520
`define CBC_OFF_PBUS1 12'h524
`define CBC_OFF_MEM_BUS 12'h540
`define CBC_OFF_DISPLAY_ENGINE_CLK 12'h600
`define CBC_OFF_DE_BUS 12'h60C
`define CBC_OFF_DEINTERLACER_CLK 12'h620
`define CBC_OFF_DI_BUS 12'h62C

`define CBC_RST_CORE_PLL_BIAS 32'h8010_0000
`define CBC_RST_PLL_BIAS 32'h0003_0000
`define CBC_RST_TUNING 32'h4440_4000
`define CBC_RST_CORE_CONFIG 32'h0000_0301
`define CBC_RST_CORE_GATE 32'h8000_0000
`define CBC_RST_MEM_BUS 32'hC000_0000
`define CBC_RST_DISPLAY_ENGINE_CLK 32'hC000_0000
`define CBC_RST_ZERO 32'h0000_0000

`define CBC_MSK_CORE_PLL_BIAS 32'h801F_0000
`define CBC_MSK_PLL_BIAS 32'h001F_0000
`define CBC_MSK_TUNING 32'h777F_FF80
`define CBC_MSK_CORE_CONFIG 32'h0703_0303
`define CBC_MSK_CORE_GATE 32'h8000_0000
`define CBC_MSK_SYS_BUS 32'h0300_0303
`define CBC_MSK_PBUS 32'h0300_031F
`define CBC_MSK_MEM_BUS 32'h4000_0000
`define CBC_MSK_DEV_CLK 32'h8700_001F
`define CBC_MSK_DEV_BUS 32'h0001_0001

`define CBC_GATE_KEY 16'h16AA
`define CBC_MEM_BUS_DIV 8'h04

`define CBC_GATE_BIT 31
`define CBC_MEM_RST_BIT 30
`define CBC_SRC_LSB 24
`define CBC_P_LSB 16
`define CBC_N_LSB 8
`define CBC_M_LSB 0
`define CBC_CP_LSB 16
`define CBC_VCO_LSB 28
`define CBC_GAIN_LSB 24
`define CBC_CNT_LSB 16
`define CBC_OVR0_BIT 15
`define CBC_VIN_LSB 8
`define CBC_OVR1_BIT 7
`define CBC_BUS_RST_BIT 16
`define CBC_BUS_GATE_BIT 0

`endif

// [cbc_pkg.sv]
// Types shared by the core and bus clock unit and its users.
// Assumes the constants of cbc_cfg.svh.
package cbc_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cbc_bus_req_s;

  typedef struct packed {
    logic [2:0] core_src;
    logic [1:0] core_pll_output_divider;
    logic [1:0] core_second_divider;
    logic core_on;
    logic vco_reset_input;
    logic [4:0] core_charge_pump_bias;
    logic [6:0][4:0] charge_pump_bias;
    logic [2:0] vco_range;
    logic [2:0] vco_gain;
    logic [6:0] counter_initial;
    logic verify_override_0;
    logic [6:0] verify_in;
    logic verify_override_1;
    logic [1:0] sys_src;
    logic [1:0] pbus0_src;
    logic [1:0] pbus1_src;
    logic [2:0] de_src;
    logic [2:0] di_src;
    logic memory_bus_reset_n;
    logic display_engine_reset_n;
    logic display_engine_bus_gate;
    logic deinterlacer_reset_n;
    logic deinterlacer_bus_gate;
  } cbc_ctl_s;

  typedef struct packed {
    logic core_clk_en;
    logic core_axi_clk_en;
    logic system_bus_clk_en;
    logic peripheral_bus0_clk_en;
    logic peripheral_bus1_clk_en;
    logic memory_bus_clk_en;
    logic display_engine_clk_en;
    logic deinterlacer_clk_en;
  } cbc_tick_s;

endpackage

// [cbc_top.sv]
// Core and bus clock unit: register file plus divider enables for each clock.
// Assumes clk_sys stands in for every source; outputs are one-cycle enables.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "cbc_cfg.svh"
module cbc_top #(
  parameter int NREG = 19,
  parameter int NDIV = 7
) (
  input wire logic clk_sys,
  input wire logic reset,
  input cbc_pkg::cbc_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  input wire logic [6:0] pll_verify_out_pin,
  output cbc_pkg::cbc_ctl_s ctl,
  output cbc_pkg::cbc_tick_s tick
);
  import cbc_pkg::*;

  // One clock domain, so every check below shares these
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  localparam logic [11:0] OFFS [NREG] = '{
    `CBC_OFF_CORE_PLL_BIAS, `CBC_OFF_DDR_PLL_BIAS, `CBC_OFF_PERI_PLL_BIAS,
    `CBC_OFF_VIDEO_A_BIAS, `CBC_OFF_VIDEO_B_BIAS, `CBC_OFF_VE_PLL_BIAS,
    `CBC_OFF_AUDIO_A_BIAS, `CBC_OFF_AUDIO_B_BIAS, `CBC_OFF_CORE_TUNING,
    `CBC_OFF_CORE_CONFIG, `CBC_OFF_CORE_GATE, `CBC_OFF_SYS_BUS, `CBC_OFF_PBUS0,
    `CBC_OFF_PBUS1, `CBC_OFF_MEM_BUS, `CBC_OFF_DISPLAY_ENGINE_CLK, `CBC_OFF_DE_BUS,
    `CBC_OFF_DEINTERLACER_CLK, `CBC_OFF_DI_BUS};
  // Reset values
  localparam logic [31:0] RSTV [NREG] = '{
    `CBC_RST_CORE_PLL_BIAS, `CBC_RST_PLL_BIAS, `CBC_RST_PLL_BIAS, `CBC_RST_PLL_BIAS,
    `CBC_RST_PLL_BIAS, `CBC_RST_PLL_BIAS, `CBC_RST_PLL_BIAS, `CBC_RST_PLL_BIAS,
    `CBC_RST_TUNING, `CBC_RST_CORE_CONFIG, `CBC_RST_CORE_GATE, `CBC_RST_ZERO,
    `CBC_RST_ZERO, `CBC_RST_ZERO, `CBC_RST_MEM_BUS, `CBC_RST_DISPLAY_ENGINE_CLK,
    `CBC_RST_ZERO, `CBC_RST_ZERO, `CBC_RST_ZERO};
  // Writable bits; key and verify output are never stored
  localparam logic [31:0] MASK [NREG] = '{
    `CBC_MSK_CORE_PLL_BIAS, `CBC_MSK_PLL_BIAS, `CBC_MSK_PLL_BIAS, `CBC_MSK_PLL_BIAS,
    `CBC_MSK_PLL_BIAS, `CBC_MSK_PLL_BIAS, `CBC_MSK_PLL_BIAS, `CBC_MSK_PLL_BIAS,
    `CBC_MSK_TUNING, `CBC_MSK_CORE_CONFIG, `CBC_MSK_CORE_GATE, `CBC_MSK_SYS_BUS,
    `CBC_MSK_PBUS, `CBC_MSK_PBUS, `CBC_MSK_MEM_BUS, `CBC_MSK_DEV_CLK,
    `CBC_MSK_DEV_BUS, `CBC_MSK_DEV_CLK, `CBC_MSK_DEV_BUS};

  localparam int I_CPB = 0;
  localparam int I_TUNE = 8;
  localparam int I_CORE = 9;
  localparam int I_GATE = 10;
  localparam int I_SYS = 11;
  localparam int I_PB0 = 12;
  localparam int I_PB1 = 13;
  localparam int I_MBUS = 14;
  localparam int I_DE = 15;
  localparam int I_DEB = 16;
  localparam int I_DI = 17;
  localparam int I_DIB = 18;

  localparam int D_SYS = 0;
  localparam int D_PB0 = 1;
  localparam int D_PB1 = 2;
  localparam int D_AXI = 3;
  localparam int D_DE = 4;
  localparam int D_DI = 5;
  localparam int D_MBUS = 6;

  // Returns {hit, index}
  function automatic logic [5:0] reg_index(input logic [11:0] a);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < NREG; i++) begin
      if (a == OFFS[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Last count of a period of (m + 1) * 2^n source cycles
  function automatic logic [7:0] div_last(input logic [4:0] m, input logic [1:0] n);
    logic [9:0] p;
    p = (10'(m) + 10'h001) << n;
    return 8'(p - 10'h001);
  endfunction

  logic [31:0] reg_q [NREG];
  logic [31:0] rdata_q;
  logic [6:0] vin_s1_q;
  logic [6:0] vin_s2_q;
  logic [6:0] vin_s3_q;
  logic [6:0] verify_q;
  logic [7:0] cnt_q [NDIV];
  logic [7:0] lim_q [NDIV];
  logic [2:0] src_q [NDIV];
  logic [NDIV-1:0] tick_q;

  logic [7:0] want_lim [NDIV];
  logic [2:0] want_src [NDIV];
  logic [NDIV-1:0] adv;
  logic [NDIV-1:0] period_end;

  // Bus decode
  wire [5:0] dec = reg_index(bus_req.addr);
  wire hit = dec[5];
  wire [4:0] idx = dec[4:0];
  wire key_ok = bus_req.wdata[15:0] == `CBC_GATE_KEY;
  wire gate_wr = bus_req.wr && hit && (idx == 5'(I_GATE));
  wire reg_we = bus_req.wr && hit && ((idx != 5'(I_GATE)) || key_ok);
  wire [31:0] stored = hit ? reg_q[idx] : 32'h0000_0000;
  wire [31:0] rd_word = (hit && idx == 5'(I_TUNE)) ? (stored | {25'h0000000, verify_q})
                                                   : stored;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NREG; i++) begin
        reg_q[i] <= RSTV[i] & MASK[i];
      end
    end else if (reg_we) begin
      reg_q[idx] <= bus_req.wdata & MASK[idx];
    end
  end

  // Each accepted write shows on its control output one cycle later, except source selects, which wait for a period end
  a_memory_bus_reset_write: assert property (
    bus_req.wr && hit && idx == 5'(I_MBUS)
    |=> ctl.memory_bus_reset_n == $past(bus_req.wdata[`CBC_MEM_RST_BIT]))
    else $error("memory bus reset bit not written");

  a_core_div_write: assert property (
    bus_req.wr && hit && idx == 5'(I_CORE)
    |=> ctl.core_second_divider == $past(bus_req.wdata[`CBC_N_LSB +: 2])
    && ctl.core_pll_output_divider == $past(bus_req.wdata[`CBC_P_LSB +: 2]))
    else $error("core divider fields not written");

  a_tune_write: assert property (
    bus_req.wr && hit && idx == 5'(I_TUNE)
    |=> ctl.vco_gain == $past(bus_req.wdata[`CBC_GAIN_LSB +: 3])
    && ctl.counter_initial == $past(bus_req.wdata[`CBC_CNT_LSB +: 7]))
    else $error("tuning fields not written");

  a_verify_in_write: assert property (
    bus_req.wr && hit && idx == 5'(I_TUNE)
    |=> ctl.verify_in == $past(bus_req.wdata[`CBC_VIN_LSB +: 7]))
    else $error("verify input not written");

  a_verify_ro: assert property (
    bus_req.wr && hit && idx == 5'(I_TUNE) |=> reg_q[I_TUNE][6:0] == 7'h00)
    else $error("read-only verify bits took a write");

  a_bias_write: assert property (
    bus_req.wr && hit && idx == 5'(I_CPB + 1)
    |=> ctl.charge_pump_bias[0] == $past(bus_req.wdata[`CBC_CP_LSB +: 5]))
    else $error("ddr pll bias not written");

  a_de_bus_write: assert property (
    bus_req.wr && hit && idx == 5'(I_DEB)
    |=> ctl.display_engine_bus_gate == $past(bus_req.wdata[`CBC_BUS_GATE_BIT]))
    else $error("display bus gate not written");

  // Read data live for exactly one cycle after the strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= bus_req.rd ? rd_word : 32'h0000_0000;
    end
  end

  // Idle zero keeps a stale word from passing as fresh data
  a_rdata_idle: assert property (
    !bus_req.rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  a_key_reads_zero: assert property (
    bus_req.rd && hit && idx == 5'(I_GATE) |=> bus_rdata[15:0] == 16'h0000)
    else $error("gate key read back");

  // Analog verify output: settle filter so a half-changed word is never read
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      vin_s1_q <= 7'h00;
      vin_s2_q <= 7'h00;
      vin_s3_q <= 7'h00;
      verify_q <= 7'h00;
    end else begin
      vin_s1_q <= pll_verify_out_pin;
      vin_s2_q <= vin_s1_q;
      vin_s3_q <= vin_s2_q;
      if (vin_s2_q == vin_s3_q) begin
        verify_q <= vin_s3_q;
      end
    end
  end

  a_verify_readback: assert property (
    bus_req.rd && hit && idx == 5'(I_TUNE) |=> bus_rdata[6:0] == $past(verify_q))
    else $error("verify output not read back");

  // Divider targets
  assign want_lim[D_SYS] = div_last({3'h0, reg_q[I_SYS][`CBC_M_LSB +: 2]},
                                    reg_q[I_SYS][`CBC_N_LSB +: 2]);
  assign want_lim[D_PB0] = div_last(reg_q[I_PB0][`CBC_M_LSB +: 5],
                                    reg_q[I_PB0][`CBC_N_LSB +: 2]);
  assign want_lim[D_PB1] = div_last(reg_q[I_PB1][`CBC_M_LSB +: 5],
                                    reg_q[I_PB1][`CBC_N_LSB +: 2]);
  assign want_lim[D_AXI] = div_last({3'h0, reg_q[I_CORE][`CBC_M_LSB +: 2]}, 2'h0);
  assign want_lim[D_DE] = div_last(reg_q[I_DE][`CBC_M_LSB +: 5], 2'h0);
  assign want_lim[D_DI] = div_last(reg_q[I_DI][`CBC_M_LSB +: 5], 2'h0);
  assign want_lim[D_MBUS] = `CBC_MEM_BUS_DIV - 8'h01;

  assign want_src[D_SYS] = {1'b0, reg_q[I_SYS][`CBC_SRC_LSB +: 2]};
  assign want_src[D_PB0] = {1'b0, reg_q[I_PB0][`CBC_SRC_LSB +: 2]};
  assign want_src[D_PB1] = {1'b0, reg_q[I_PB1][`CBC_SRC_LSB +: 2]};
  assign want_src[D_AXI] = reg_q[I_CORE][`CBC_SRC_LSB +: 3];
  assign want_src[D_DE] = reg_q[I_DE][`CBC_SRC_LSB +: 3];
  assign want_src[D_DI] = reg_q[I_DI][`CBC_SRC_LSB +: 3];
  assign want_src[D_MBUS] = 3'h0;

  // Source code 10 of a peripheral bus counts system bus periods
  assign adv[D_SYS] = 1'b1;
  assign adv[D_PB0] = (src_q[D_PB0] == 3'h2) ? tick_q[D_SYS] : 1'b1;
  assign adv[D_PB1] = (src_q[D_PB1] == 3'h2) ? tick_q[D_SYS] : 1'b1;
  assign adv[D_AXI] = reg_q[I_GATE][`CBC_GATE_BIT];
  assign adv[D_DE] = reg_q[I_DE][`CBC_GATE_BIT];
  assign adv[D_DI] = reg_q[I_DI][`CBC_GATE_BIT];
  assign adv[D_MBUS] = 1'b1;

  always_comb begin
    for (int i = 0; i < NDIV; i++) begin
      period_end[i] = adv[i] && (cnt_q[i] >= lim_q[i]);
    end
  end

  // New ratio and source only at a period boundary, so no runt pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NDIV; i++) begin
        cnt_q[i] <= 8'h00;
        lim_q[i] <= 8'h00;
        src_q[i] <= 3'h0;
      end
      tick_q <= '0;
    end else begin
      tick_q <= period_end;
      for (int i = 0; i < NDIV; i++) begin
        if (period_end[i]) begin
          cnt_q[i] <= 8'h00;
          lim_q[i] <= want_lim[i];
          src_q[i] <= want_src[i];
        end else if (adv[i]) begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end
      end
    end
  end

  a_axi_gate_off: assert property (
    !ctl.core_on |=> !tick_q[D_AXI])
    else $error("core axi clock ticked while gated");

  a_di_gate_off: assert property (
    !reg_q[I_DI][`CBC_GATE_BIT] |=> !tick_q[D_DI])
    else $error("deinterlacer clock ticked while gated");

  // Source only moves at a period end, so consumers never see a runt
  a_sys_src_edge: assert property (
    $changed(ctl.sys_src) |-> $past(period_end[D_SYS]))
    else $error("system bus source changed mid period");

  a_pb1_on_sys: assert property (
    $past(src_q[D_PB1]) == 3'h2 && tick_q[D_PB1] |-> $past(tick_q[D_SYS]))
    else $error("peripheral bus 1 ticked off system bus");

  // Outputs, all straight from flip-flops
  assign bus_rdata = rdata_q;
  assign ctl.core_src = src_q[D_AXI];
  assign ctl.core_pll_output_divider = reg_q[I_CORE][`CBC_P_LSB +: 2];
  assign ctl.core_second_divider = reg_q[I_CORE][`CBC_N_LSB +: 2];
  assign ctl.core_on = reg_q[I_GATE][`CBC_GATE_BIT];
  assign ctl.vco_reset_input = reg_q[I_CPB][`CBC_GATE_BIT];
  assign ctl.core_charge_pump_bias = reg_q[I_CPB][`CBC_CP_LSB +: 5];
  // Element 0 is the DDR PLL, then upward in offset order
  assign ctl.charge_pump_bias = {reg_q[7][`CBC_CP_LSB +: 5], reg_q[6][`CBC_CP_LSB +: 5],
                                 reg_q[5][`CBC_CP_LSB +: 5], reg_q[4][`CBC_CP_LSB +: 5],
                                 reg_q[3][`CBC_CP_LSB +: 5], reg_q[2][`CBC_CP_LSB +: 5],
                                 reg_q[1][`CBC_CP_LSB +: 5]};
  assign ctl.vco_range = reg_q[I_TUNE][`CBC_VCO_LSB +: 3];
  assign ctl.vco_gain = reg_q[I_TUNE][`CBC_GAIN_LSB +: 3];
  assign ctl.counter_initial = reg_q[I_TUNE][`CBC_CNT_LSB +: 7];
  assign ctl.verify_override_0 = reg_q[I_TUNE][`CBC_OVR0_BIT];
  assign ctl.verify_in = reg_q[I_TUNE][`CBC_VIN_LSB +: 7];
  assign ctl.verify_override_1 = reg_q[I_TUNE][`CBC_OVR1_BIT];
  assign ctl.sys_src = src_q[D_SYS][1:0];
  assign ctl.pbus0_src = src_q[D_PB0][1:0];
  assign ctl.pbus1_src = src_q[D_PB1][1:0];
  assign ctl.de_src = src_q[D_DE];
  assign ctl.di_src = src_q[D_DI];
  assign ctl.memory_bus_reset_n = reg_q[I_MBUS][`CBC_MEM_RST_BIT];
  assign ctl.display_engine_reset_n = reg_q[I_DEB][`CBC_BUS_RST_BIT];
  assign ctl.display_engine_bus_gate = reg_q[I_DEB][`CBC_BUS_GATE_BIT];
  assign ctl.deinterlacer_reset_n = reg_q[I_DIB][`CBC_BUS_RST_BIT];
  assign ctl.deinterlacer_bus_gate = reg_q[I_DIB][`CBC_BUS_GATE_BIT];

  assign tick.core_clk_en = reg_q[I_GATE][`CBC_GATE_BIT];
  assign tick.core_axi_clk_en = tick_q[D_AXI];
  assign tick.system_bus_clk_en = tick_q[D_SYS];
  assign tick.peripheral_bus0_clk_en = tick_q[D_PB0];
  assign tick.peripheral_bus1_clk_en = tick_q[D_PB1];
  assign tick.memory_bus_clk_en = tick_q[D_MBUS];
  assign tick.display_engine_clk_en = tick_q[D_DE];
  assign tick.deinterlacer_clk_en = tick_q[D_DI];

  a_gate_key_hold: assert property (
    gate_wr && !key_ok |=> $stable(ctl.core_on))
    else $error("core gate changed without key");

  a_gate_key_load: assert property (
    gate_wr && key_ok |=> ctl.core_on == $past(bus_req.wdata[31]))
    else $error("core gate ignored keyed write");

  a_unmapped_zero: assert property (
    bus_req.rd && !hit |=> bus_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_axi_half_rate: assert property (
    tick_q[D_AXI] && lim_q[D_AXI] == 8'h01 && ctl.core_on ##1 ctl.core_on
    |-> !tick_q[D_AXI] ##1 tick_q[D_AXI])
    else $error("core axi divide by two wrong");

  a_mbus_quarter: assert property (
    tick_q[D_MBUS] |=> !tick_q[D_MBUS] [*3] ##1 tick_q[D_MBUS])
    else $error("memory bus not divided by four");

  a_ratio_at_edge: assert property (
    $changed(lim_q[D_SYS]) |-> $past(cnt_q[D_SYS] >= lim_q[D_SYS]))
    else $error("system bus ratio changed mid period");

  a_verify_settled: assert property (
    $changed(verify_q) |-> $past(vin_s2_q == vin_s3_q))
    else $error("verify output took unsettled value");

  a_de_gate_off: assert property (
    !reg_q[I_DE][`CBC_GATE_BIT] |=> !tick_q[D_DE])
    else $error("display clock ticked while gated");

endmodule // cbc_top

// [core_and_bus_clock_unit_tb_top.sv]
// Self-checking bench for the core and bus clock unit: registers, key gate, dividers.
// Assumes cbc_top, cbc_pkg and cbc_cfg.svh; registers reached over a one-cycle strobe port.
`timescale 1ns/1ps
`include "cbc_cfg.svh"
`define CHECK(n, e, g) chk(n, 32'(e), 32'(g))
module core_and_bus_clock_unit_tb_top;
  import cbc_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] rst; logic [31:0] ones; logic [31:0] zro;} cbc_row_s;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  cbc_bus_req_s req = '0;
  logic [31:0] bus_rdata;
  logic [6:0] pin = 7'h00;
  cbc_ctl_s ctl;
  cbc_tick_s tick;
  logic [7:0] tk;
  logic [31:0] v;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  // Address, reset read, read after all ones, read after all zeros
  cbc_row_s rows [20] = '{
    '{12'h300, 32'h8010_0000, 32'h801F_0000, 32'h0},
    '{12'h310, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h320, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h340, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h348, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h358, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h378, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h380, 32'h0003_0000, 32'h001F_0000, 32'h0},
    '{12'h400, 32'h4440_4000, 32'h777F_FF80, 32'h0},
    '{12'h500, 32'h0000_0301, 32'h0703_0303, 32'h0},
    '{12'h504, 32'h8000_0000, 32'h8000_0000, 32'h8000_0000},
    '{12'h510, 32'h0, 32'h0300_0303, 32'h0},
    '{12'h520, 32'h0, 32'h0300_031F, 32'h0},
    '{12'h524, 32'h0, 32'h0300_031F, 32'h0},
    '{12'h540, 32'h4000_0000, 32'h4000_0000, 32'h0},
    '{12'h600, 32'h8000_0000, 32'h8700_001F, 32'h0},
    '{12'h60C, 32'h0, 32'h0001_0001, 32'h0},
    '{12'h620, 32'h0, 32'h8700_001F, 32'h0},
    '{12'h62C, 32'h0, 32'h0001_0001, 32'h0},
    '{12'h7FC, 32'h0, 32'h0, 32'h0}};

  cbc_top uut (.clk_sys(clk_sys), .reset(reset), .bus_req(req), .bus_rdata(bus_rdata),
    .pll_verify_out_pin(pin), .ctl(ctl), .tick(tick));
  assign tk = tick;

  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask

  // First pass syncs, second skips a period that may straddle a reconfiguration
  task automatic period(input int b, input int e, input string nm);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (tk[b] !== 1'b1 && n < 300);
    end
    `CHECK(nm, e, n);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("MISMATCH timeout expected %0d seen %0d", LIMIT, cycles);
      summarize();
    end
  end

  initial begin
    repeat (11) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHECK("gate in reset", tick.core_clk_en, 1'b1);
    `CHECK("vco reset in", ctl.vco_reset_input, 1'b1);
    `CHECK("mbus released", ctl.memory_bus_reset_n, 1'b1);
    `CHECK("vco range", 3'h4, ctl.vco_range);
    `CHECK("vco gain", 3'h4, ctl.vco_gain);
    `CHECK("counter init", 7'h40, ctl.counter_initial);
    `CHECK("verify in", 7'h40, ctl.verify_in);
    `CHECK("core bias", 5'h10, ctl.core_charge_pump_bias);
    @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      `CHECK("reset read", rows[i].rst, v);
      wr(rows[i].a, 32'hFFFF_FFFF);
      rd(rows[i].a, v);
      `CHECK("ones read", rows[i].ones, v);
      wr(rows[i].a, 32'h0);
      rd(rows[i].a, v);
      `CHECK("zeros read", rows[i].zro, v);
    end
    `CHECK("mbus assert", ctl.memory_bus_reset_n, 1'b0);
    wr(12'h340, 32'h0015_0000);
    `CHECK("bias field", ctl.charge_pump_bias[2], 5'h15);
    wr(12'h60C, 32'h0001_0001);
    `CHECK("de reset", ctl.display_engine_reset_n, 1'b1);
    `CHECK("de bus gate", ctl.display_engine_bus_gate, 1'b1);
    period(2, 4, "mbus period");
    wr(12'h500, 32'h0602_0202);
    `CHECK("p code", ctl.core_pll_output_divider, 2'h2);
    `CHECK("n code", ctl.core_second_divider, 2'h2);
    period(6, 3, "axi period");
    `CHECK("core src", ctl.core_src, 3'h6);
    wr(12'h510, 32'h0300_0202);
    period(5, 12, "sys period");
    `CHECK("sys src", ctl.sys_src, 2'h3);
    wr(12'h520, 32'h0100_0104);
    period(4, 10, "pbus0 period");
    `CHECK("pbus0 src", ctl.pbus0_src, 2'h1);
    wr(12'h524, 32'h0200_0000);
    period(3, 12, "pbus1 period");
    `CHECK("pbus1 src", 2'h2, ctl.pbus1_src);
    wr(12'h600, 32'h8300_0006);
    period(1, 7, "de period");
    `CHECK("de src", ctl.de_src, 3'h3);
    wr(12'h620, 32'h8100_0003);
    period(0, 4, "di period");
    `CHECK("di src", ctl.di_src, 3'h1);
    wr(12'h600, 32'h0300_0006);
    n = 0;
    repeat (50) begin
      @(negedge clk_sys);
      n += tk[1] === 1'b1;
    end
    `CHECK("de gated", 0, n);
    wr(12'h504, 32'h0000_1234);
    `CHECK("bad key", tick.core_clk_en, 1'b1);
    wr(12'h504, 32'h0000_16AA);
    rd(12'h504, v);
    `CHECK("gate off", v, 32'h0);
    `CHECK("gate off en", tick.core_clk_en, 1'b0);
    `CHECK("core on", 1'b0, ctl.core_on);
    wr(12'h504, 32'h8000_16AB);
    `CHECK("near key", tick.core_clk_en, 1'b0);
    wr(12'h504, 32'h8000_16AA);
    `CHECK("gate on", tick.core_clk_en, 1'b1);
    wr(12'h400, 32'h0000_8080);
    `CHECK("override 0", 1'b1, ctl.verify_override_0);
    `CHECK("override 1", 1'b1, ctl.verify_override_1);
    @(posedge clk_sys);
    pin <= 7'h55;
    wr(12'h400, 32'h0000_002A);
    repeat (8) @(posedge clk_sys);
    rd(12'h400, v);
    `CHECK("verify out", v, 32'h0000_0055);
    // Write then read with no gap between the strobes
    @(posedge clk_sys);
    req.addr <= 12'h524;
    req.wdata <= 32'h0300_0215;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    @(negedge clk_sys);
    `CHECK("back to back", bus_rdata, 32'h0300_0215);
    @(negedge clk_sys);
    `CHECK("rdata drops", bus_rdata, 32'h0);
    wr(12'h504, 32'h0000_16AA);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(12'h504, v);
    `CHECK("second reset gate", v, 32'h8000_0000);
    rd(12'h500, v);
    `CHECK("second reset cfg", v, 32'h0000_0301);
    summarize();
  end
endmodule // core_and_bus_clock_unit_tb_top
